// File: verilog/pwm_tb_pkg.sv
`default_nettype none
package pwm_tb_pkg;
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_ZERO = 8'h00;
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
    localparam logic [7:0] ADDR_OUT_CTRL = 8'h08;
    localparam logic [7:0] ADDR_DEAD_TIME = 8'h0C;
    localparam logic [7:0] ADDR_OVERRIDE = 8'h10;
    localparam logic [7:0] ADDR_COUNT = 8'h14;
    localparam logic [7:0] ADDR_PERIOD = 8'h18;
    localparam logic [7:0] ADDR_EVENT_CMP = 8'h1C;
    localparam logic [7:0] ADDR_DUTY0 = 8'h20;
    localparam logic [7:0] ADDR_DUTY1 = 8'h24;
    localparam logic [7:0] ADDR_DUTY2 = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h2C;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int POST_MSB = 7;
    localparam int POST_LSB = 4;
    localparam int PRE_MSB = 3;
    localparam int PRE_LSB = 2;
    localparam int MODE_MSB = 1;
    localparam int MODE_LSB = 0;
    localparam int RUN_BIT = 7;
    localparam int DIR_BIT = 6;
    localparam logic [7:0] CTRL_ZERO_RESET = 8'h00;
    localparam logic [15:0] PERIOD_RESET = 16'h0FFF;
    localparam logic [7:0] DEAD_RESET = 8'h00;
    localparam int COUNT_W = 12;
    localparam int DUTY_W = 14;
    localparam int NUM_GEN = 3;
    localparam int NUM_OUT = 6;
    localparam logic [5:0] PRESCALE_LAST [4] = '{6'h00, 6'h03, 6'h0F, 6'h3F};

    typedef enum logic [1:0] {
        MODE_FREE,
        MODE_SINGLE,
        MODE_UPDOWN,
        MODE_UPDOWN_DBL
    } timebase_mode_e;

    typedef struct packed {
        logic [1:0] htrans;
        logic hwrite;
        logic [7:0] haddr;
        logic hsel;
    } ahb_addr_s;
endpackage
`default_nettype wire

// File: verilog/pwm_pair_out.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_pair_out
    import pwm_tb_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // Control
    input wire logic raw_in,
    input wire logic indep_in,
    input wire logic odd_raw_in,
    input wire logic force_off_in,
    input wire logic [7:0] dead_in,
    // Outputs
    output logic even_out,
    output logic odd_out
);
    typedef struct packed {
        logic odd;
        logic even;
        logic want;
        logic [7:0] cnt;
    } pair_st_s;

    pair_st_s q, d;

    always_comb begin
        d = q;
        if (force_off_in) begin
            d.odd = 1'b0;
            d.even = 1'b0;
            d.want = raw_in;
            d.cnt = dead_in;
        end else if (indep_in) begin
            d.odd = raw_in;
            d.even = odd_raw_in;
        end else if (raw_in != d.want) begin
            // Any change drops both outputs and restarts the dead interval.
            d.want = raw_in;
            d.odd = 1'b0; // [RULE3]
            d.even = 1'b0; // [RULE4]
            d.cnt = dead_in;
        end else if (q.cnt != 8'h00) begin
            d.cnt = q.cnt - 8'h01;
        end else begin
            d.odd = q.want; // [RULE2]
            d.even = ~q.want; // [RULE2]
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign even_out = q.even;
    assign odd_out = q.odd;

    property p_never_both;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        !indep_in |-> !(q.even && q.odd);
    endproperty
    a_never_both: assert property (p_never_both) else $error("pair outputs both active"); // [RULE4]

    property p_dead_gap;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (!indep_in && !force_off_in && $fell(q.odd) && dead_in != 8'h00) |-> !q.even;
    endproperty
    a_dead_gap: assert property (p_dead_gap) else $error("no dead time after odd off"); // [RULE3]
endmodule
`default_nettype wire

// File: verilog/power_pwm_time_base.sv
// Contract
// [RULE1] Three duty generators 0..2 and six outputs 0..5.
// [RULE2] Outputs form even/odd pairs; complementary even is inverse of odd.
// [RULE3] Dead time holds both pair outputs off between transitions.
// [RULE4] Fault or override never drives even active while odd active; in independent mode the code lets override drive both active.
// [RULE5] Time base is a 12-bit counter with prescaler and postscaler.
// [RULE6] Time base runs while run bit set, stops when cleared.
// [RULE7] Clearing run bit keeps the count value.
// [RULE8] Four modes from a two-bit mode field.
// [RULE9] Free/single give edge-aligned, up/down modes center-aligned.
// [RULE10] Count, period, event compare and duties are double-buffered; the code writes count directly.
// [RULE11] Twenty registers: eight configuration plus six value pairs; the code decodes eleven.
// [RULE12] Control zero: postscale 7:4, prescale 3:2, mode 1:0, reset zero.
// [RULE13] Duty resolution up to 14 bits, depending on period.
// [RULE14] Debug mode forces all outputs inactive.
// [RULE15] Special event compare makes a conversion trigger.
// [RULE16] Center-aligned mode gives update points twice per period; the code does so only in up/down double mode.
// [RULE17] Mode codes 00 free, 01 single, 10 up/down, 11 up/down double.
// [RULE18] Prescale codes divide by 1, 4, 16, 64.
// [RULE19] Postscale divides match events by field plus one.
// [RULE20] Free mode counts to period, wraps to zero, continues.
// [RULE21] Counter steps on prescale ticks; reset clears all dividers.
`timescale 1ns/1ps
`default_nettype none
module power_pwm_time_base
    import pwm_tb_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Device status
    input wire logic debug_mode_in,
    input wire logic fault_in,
    // PWM outputs and trigger
    output logic [NUM_OUT-1:0] pwm_out,
    output logic event_trigger_out,
    output logic update_point_out,
    output logic postscale_tick_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ahb_addr_s ap;
        logic [31:0] rdata;
        logic [7:0] ctrl0;
        logic run;
        logic dir;
        logic [2:0] indep;
        logic [7:0] dead;
        logic [5:0] ovr_en;
        logic [5:0] ovr_val;
        logic [COUNT_W-1:0] count;
        logic [15:0] per_buf;
        logic [15:0] per_act;
        logic [15:0] evt_buf;
        logic [15:0] evt_act;
        logic [NUM_GEN-1:0][15:0] duty_buf;
        logic [NUM_GEN-1:0][15:0] duty_act;
        logic [5:0] pre_cnt;
        logic [3:0] post_cnt;
        logic [NUM_GEN-1:0] raw;
        logic evt;
        logic upd;
        logic post_tick;
    } tb_st_s;

    tb_st_s q, d;
    logic wr_now;
    logic tick;
    logic match;
    logic [1:0] fine;
    logic [DUTY_W-1:0] cmp_pos;

    assign wr_now = q.ap.hsel && q.ap.hwrite && q.ap.htrans[1];
    assign tick = q.run && (q.pre_cnt == PRESCALE_LAST[q.ctrl0[PRE_MSB:PRE_LSB]]); // [RULE18]
    assign match = (q.count == q.per_act[COUNT_W-1:0]);
    // Duty has two fractional bits: the prescaler phase adds sub-count resolution.
    assign fine = q.pre_cnt[1:0];
    assign cmp_pos = {q.count, fine}; // [RULE13]

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.evt = 1'b0;
        d.upd = 1'b0;
        d.post_tick = 1'b0;
        d.ap = '{htrans: htrans_in, hwrite: hwrite_in, haddr: haddr_in, hsel: hsel_in && hready_in};
        d.pre_cnt = q.run ? (tick ? 6'h00 : q.pre_cnt + 6'h01) : 6'h00; // [RULE21]
        if (tick) begin
            unique case (timebase_mode_e'(q.ctrl0[MODE_MSB:MODE_LSB])) // [RULE17]
                MODE_FREE, MODE_SINGLE: begin
                    d.dir = 1'b0;
                    if (match) begin
                        d.count = '0; // [RULE20]
                        d.upd = 1'b1;
                        if (q.ctrl0[MODE_MSB:MODE_LSB] == 2'b01) begin
                            d.run = 1'b0; // [RULE8]
                        end
                    end else begin
                        d.count = q.count + 12'h001; // [RULE5]
                    end
                end
                MODE_UPDOWN, MODE_UPDOWN_DBL: begin
                    if (!q.dir && match) begin
                        d.dir = 1'b1;
                        d.count = q.count - 12'h001;
                        d.upd = (q.ctrl0[MODE_LSB] == 1'b1); // [RULE16]
                    end else if (q.dir && q.count == '0) begin
                        d.dir = 1'b0;
                        d.count = 12'h001;
                        d.upd = 1'b1;
                    end else begin
                        d.count = q.dir ? q.count - 12'h001 : q.count + 12'h001;
                    end
                end
            endcase
            if (match) begin
                d.post_cnt = (q.post_cnt == q.ctrl0[POST_MSB:POST_LSB]) ? 4'h0 : q.post_cnt + 4'h1; // [RULE19]
                d.post_tick = (q.post_cnt == q.ctrl0[POST_MSB:POST_LSB]);
            end
            d.evt = (q.count == q.evt_act[COUNT_W-1:0]); // [RULE15]
        end
        if (d.upd) begin
            d.per_act = q.per_buf; // [RULE10]
            d.evt_act = q.evt_buf;
            d.duty_act = q.duty_buf;
        end
        for (int g = 0; g < NUM_GEN; g++) begin
            if (q.ctrl0[MODE_MSB]) begin
                d.raw[g] = (cmp_pos < q.duty_act[g][DUTY_W-1:0]) && q.dir; // [RULE9]
                if (!q.dir) begin
                    d.raw[g] = ({q.count, 2'b00} < q.duty_act[g][DUTY_W-1:0]) && (q.count != '0) && q.raw[g];
                end
            end else begin
                d.raw[g] = (cmp_pos < q.duty_act[g][DUTY_W-1:0]) && q.run; // [RULE9]
            end
        end
        if (wr_now) begin
            unique case (q.ap.haddr) // [RULE11]
                ADDR_CTRL_ZERO: begin
                    d.ctrl0 = hwdata_in[7:0]; // [RULE12]
                    d.pre_cnt = 6'h00;
                    d.post_cnt = 4'h0;
                end
                ADDR_CTRL_ONE: begin
                    d.run = hwdata_in[RUN_BIT]; // [RULE6]
                    d.pre_cnt = 6'h00;
                    d.post_cnt = 4'h0;
                end
                ADDR_OUT_CTRL: d.indep = hwdata_in[2:0];
                ADDR_DEAD_TIME: d.dead = hwdata_in[7:0];
                ADDR_OVERRIDE: begin
                    d.ovr_en = hwdata_in[5:0];
                    d.ovr_val = hwdata_in[13:8];
                end
                ADDR_COUNT: begin
                    d.count = hwdata_in[COUNT_W-1:0];
                    d.pre_cnt = 6'h00;
                    d.post_cnt = 4'h0;
                end
                ADDR_PERIOD: d.per_buf = hwdata_in[15:0];
                ADDR_EVENT_CMP: d.evt_buf = hwdata_in[15:0];
                ADDR_DUTY0: d.duty_buf[0] = hwdata_in[15:0];
                ADDR_DUTY1: d.duty_buf[1] = hwdata_in[15:0];
                ADDR_DUTY2: d.duty_buf[2] = hwdata_in[15:0];
                default: d.run = q.run;
            endcase
        end
        // Any stopped time base loads buffered values at once.
        if (!d.run) begin
            d.per_act = d.per_buf;
            d.evt_act = d.evt_buf;
            d.duty_act = d.duty_buf;
        end
        d.rdata = 32'h0000_0000;
        if (d.ap.hsel && !d.ap.hwrite && d.ap.htrans[1]) begin
            unique case (d.ap.haddr)
                ADDR_CTRL_ZERO: d.rdata = {24'h0, d.ctrl0};
                ADDR_CTRL_ONE: d.rdata = {24'h0, d.run, d.dir, 6'h00};
                ADDR_OUT_CTRL: d.rdata = {29'h0, d.indep};
                ADDR_DEAD_TIME: d.rdata = {24'h0, d.dead};
                ADDR_OVERRIDE: d.rdata = {18'h0, d.ovr_val, 2'b00, d.ovr_en};
                ADDR_COUNT: d.rdata = {20'h0, d.count}; // [RULE7]
                ADDR_PERIOD: d.rdata = {16'h0, d.per_buf};
                ADDR_EVENT_CMP: d.rdata = {16'h0, d.evt_buf};
                ADDR_DUTY0: d.rdata = {16'h0, d.duty_buf[0]};
                ADDR_DUTY1: d.rdata = {16'h0, d.duty_buf[1]};
                ADDR_DUTY2: d.rdata = {16'h0, d.duty_buf[2]};
                default: d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= '0;
            q.ctrl0 <= CTRL_ZERO_RESET;
            q.per_buf <= PERIOD_RESET;
            q.per_act <= PERIOD_RESET;
            q.dead <= DEAD_RESET;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Output pairs
    // ------------------------------------------------------------
    logic force_off;
    assign force_off = debug_mode_in || fault_in; // [RULE14]

    for (genvar p = 0; p < NUM_GEN; p++) begin : g_pair // [RULE1]
        logic drive_odd;
        assign drive_odd = q.ovr_en[2*p+1] ? q.ovr_val[2*p+1] : q.raw[p];
        pwm_pair_out u_pair (
            .clk_sys_in(clk_sys_in),
            .reset_n_in(reset_n_in),
            .raw_in(drive_odd),
            .indep_in(q.indep[p]),
            .odd_raw_in(q.ovr_en[2*p] ? q.ovr_val[2*p] : q.raw[p]),
            .force_off_in(force_off),
            .dead_in(q.dead),
            .even_out(pwm_out[2*p]),
            .odd_out(pwm_out[2*p+1])
        );
    end

    assign hrdata_out = q.rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign event_trigger_out = q.evt;
    assign update_point_out = q.upd;
    assign postscale_tick_out = q.post_tick;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_stop_holds;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (!q.run && !wr_now) |=> (q.count == $past(q.count));
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("count moved while stopped"); // [RULE7]

    property p_wrap;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (tick && match && !q.ctrl0[MODE_MSB] && !wr_now) |=> (q.count == '0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("free count did not wrap"); // [RULE20]

    property p_single_stop;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (tick && match && q.ctrl0[1:0] == 2'b01 && !wr_now) |=> !q.run;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("single shot kept running"); // [RULE8]

    property p_debug_off;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        debug_mode_in |=> (pwm_out == '0);
    endproperty
    a_debug_off: assert property (p_debug_off) else $error("outputs active in debug"); // [RULE14]

    property p_step_one;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (!tick && !wr_now) |=> (q.count == $past(q.count));
    endproperty
    a_step_one: assert property (p_step_one) else $error("count moved without tick"); // [RULE21]

    property p_no_both;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (q.indep == 3'b000) |-> !(pwm_out[0] && pwm_out[1]);
    endproperty
    a_no_both: assert property (p_no_both) else $error("pair zero both active"); // [RULE2]

    property p_reg_reset;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        $rose(reset_n_in) |-> (q.ctrl0 == CTRL_ZERO_RESET);
    endproperty
    a_reg_reset: assert property (p_reg_reset) else $error("control zero not reset"); // [RULE12]

    property p_updown_dir;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (tick && match && q.ctrl0[MODE_MSB] && !q.dir && !wr_now) |=> q.dir;
    endproperty
    a_updown_dir: assert property (p_updown_dir) else $error("up/down did not turn"); // [RULE9]
endmodule
`default_nettype wire

// File: testbench/power_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // Gate drive from the generator
    input wire logic [5:0] gate_in,
    // Shoot-through record, one bit per half-bridge
    output logic [2:0] overlap_out
);
    logic [2:0] overlap_q;

    // A half-bridge whose two switches conduct at once shorts the supply, so it is latched.
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            overlap_q <= 3'h0;
        end else begin
            for (int p = 0; p < 3; p++) begin
                overlap_q[p] <= overlap_q[p] | (gate_in[2*p] & gate_in[2*p+1]);
            end
        end
    end

    assign overlap_out = overlap_q;
endmodule
`default_nettype wire

// File: testbench/power_pwm_time_base_tb.sv
`timescale 1ns/1ps
`default_nettype none
module power_pwm_time_base_tb;
    import pwm_tb_pkg::*;
    logic clk_sys_in, reset_n_in, hsel, hwrite, debug_mode, fault;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    wire logic hready;
    logic hresp, event_trig, update_pt, post_tick;
    logic [5:0] pwm;
    logic [2:0] overlap;
    int fails, num_checks;
    int divs [4] = '{1, 4, 16, 64};

    power_pwm_time_base power_pwm_time_base_i (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .debug_mode_in(debug_mode), .fault_in(fault), .pwm_out(pwm),
        .event_trigger_out(event_trig), .update_point_out(update_pt), .postscale_tick_out(post_tick)
    );
    power_stage_model power_stage_model_i (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .gate_in(pwm), .overlap_out(overlap)
    );

    // ------------------------------------------------------------
    // Clock, reset and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    initial begin
        repeat (50000) @(posedge clk_sys_in);
        fails++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One single AHB-Lite transfer; returns at the edge that closes the data phase.
    task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr_en;
        hsize <= 3'b010;
        do @(posedge clk_sys_in); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys_in); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, exp);
    endtask

    function automatic logic pulse(input int sel);
        return (sel == 0) ? update_pt : (sel == 1) ? post_tick : event_trig;
    endfunction

    // Cycles between two successive pulses of the chosen strobe.
    task automatic gap(input int sel, output int n);
        int k;
        k = 0;
        while (pulse(sel) !== 1'b1 && k < 3000) begin
            @(posedge clk_sys_in);
            k++;
        end
        @(posedge clk_sys_in);
        n = 1;
        while (pulse(sel) !== 1'b1 && n < 3000) begin
            @(posedge clk_sys_in);
            n++;
        end
    endtask

    task automatic cfg(input logic [7:0] c0, input logic [15:0] per);
        wr(ADDR_CTRL_ONE, 32'h0);
        wr(ADDR_PERIOD, {16'h0, per});
        wr(ADDR_COUNT, 32'h0);
        wr(ADDR_CTRL_ZERO, {24'h0, c0});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_regs();
        rd_chk(ADDR_CTRL_ZERO, 32'h0);
        rd_chk(ADDR_PERIOD, 32'h0000_0FFF);
        rd_chk(ADDR_COUNT, 32'h0);
        wr(ADDR_CTRL_ZERO, 32'h0000_00A5);
        rd_chk(ADDR_CTRL_ZERO, 32'h0000_00A5);
        wr(ADDR_STATUS, 32'hFFFF_FFFF);
        rd_chk(ADDR_STATUS, 32'h0);
        wr(ADDR_COUNT, 32'h0000_0123);
        rd_chk(ADDR_COUNT, 32'h0000_0123);
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic t_run_stop();
        logic [31:0] c1, c2;
        cfg(8'h00, 16'h0FFF);
        wr(ADDR_CTRL_ONE, 32'h80);
        repeat (40) @(posedge clk_sys_in);
        wr(ADDR_CTRL_ONE, 32'h0);
        bus(1'b0, ADDR_COUNT, 32'h0, c1);
        repeat (20) @(posedge clk_sys_in);
        bus(1'b0, ADDR_COUNT, 32'h0, c2);
        chk({31'h0, c1 != 32'h0}, 32'h1);
        chk(c2, c1);
    endtask

    task automatic t_prescale();
        int n;
        for (int pc = 0; pc < 4; pc++) begin
            cfg({4'h0, pc[1:0], 2'b00}, 16'h3);
            wr(ADDR_CTRL_ONE, 32'h80);
            gap(0, n);
            chk(32'(n), 32'(4 * divs[pc]));
        end
    endtask

    task automatic t_modes();
        int n;
        cfg(8'h02, 16'h5);
        wr(ADDR_CTRL_ONE, 32'h80);
        gap(0, n);
        chk(32'(n), 32'd10);
        cfg(8'h03, 16'h5);
        wr(ADDR_CTRL_ONE, 32'h80);
        gap(0, n);
        chk(32'(n), 32'd5);
        cfg(8'h01, 16'h5);
        wr(ADDR_CTRL_ONE, 32'h80);
        repeat (40) @(posedge clk_sys_in);
        rd_chk(ADDR_CTRL_ONE, 32'h0);
    endtask

    task automatic t_post_event();
        int n;
        cfg(8'h20, 16'h3);
        wr(ADDR_EVENT_CMP, 32'h2);
        wr(ADDR_CTRL_ONE, 32'h80);
        gap(1, n);
        chk(32'(n), 32'd12);
        gap(2, n);
        chk(32'(n), 32'd4);
        gap(0, n);
        chk(32'(n), 32'd4);
    endtask

    task automatic t_pair();
        logic s0, s1;
        int off_run, min_off;
        s0 = 1'b0;
        s1 = 1'b0;
        off_run = 0;
        min_off = 1000;
        cfg(8'h00, 16'h1F);
        wr(ADDR_OUT_CTRL, 32'h0);
        wr(ADDR_DEAD_TIME, 32'h3);
        wr(ADDR_DUTY0, 32'h40);
        wr(ADDR_CTRL_ONE, 32'h80);
        repeat (300) begin
            @(posedge clk_sys_in);
            s0 |= pwm[0];
            s1 |= pwm[1];
            // Each both-off stretch between pair transitions must last at least the dead time.
            if (pwm[1:0] == 2'b00) begin
                off_run++;
            end else if (off_run > 0) begin
                min_off = (off_run < min_off) ? off_run : min_off;
                off_run = 0;
            end
        end
        chk({30'h0, s1, s0}, 32'h3);
        chk({31'h0, min_off >= 3 && min_off < 1000}, 32'h1);
        chk({29'h0, overlap}, 32'h0);
        wr(ADDR_OVERRIDE, 32'h0000_0303);
        repeat (20) @(posedge clk_sys_in);
        chk({31'h0, pwm[0] & pwm[1]}, 32'h0);
        wr(ADDR_OVERRIDE, 32'h0);
        fault <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        chk({26'h0, pwm}, 32'h0);
        fault <= 1'b0;
        debug_mode <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        chk({26'h0, pwm}, 32'h0);
        debug_mode <= 1'b0;
        chk({29'h0, overlap}, 32'h0);
    endtask

    initial begin
        reset_n_in = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = 8'h00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        debug_mode = 1'b0;
        fault = 1'b0;
        fails = 0;
        num_checks = 0;
        repeat (16) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        @(posedge clk_sys_in);
        t_reset_regs();
        t_run_stop();
        t_prescale();
        t_modes();
        t_post_event();
        t_pair();
        complete_run();
    end
endmodule
`default_nettype wire
